// >>> rtl/dsac_pkg.sv
package dsac_pkg;
  // Clock rate of the control logic
  localparam int unsigned CLOCK_HZ         = 100_000_000;
  // Key timing, in milliseconds
  localparam int unsigned DEBOUNCE_MS      = 20;
  localparam int unsigned LONG_PRESS_MS    = 1000;
  // Barrier sequence timing, in milliseconds
  localparam int unsigned WARN_LEAD_MS     = 3000;
  localparam int unsigned BARRIER_PAUSE_MS = 2000;
  localparam int unsigned SOUND_TAIL_MS    = 1000;
  // Derived cycle counts
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLOCK_HZ / 1000);
  localparam int unsigned LONG_CYC     = LONG_PRESS_MS * (CLOCK_HZ / 1000);
  localparam int unsigned WARN_CYC     = WARN_LEAD_MS * (CLOCK_HZ / 1000);
  localparam int unsigned PAUSE_CYC    = BARRIER_PAUSE_MS * (CLOCK_HZ / 1000);
  localparam int unsigned TAIL_CYC     = SOUND_TAIL_MS * (CLOCK_HZ / 1000);
  // Block geometry
  localparam int unsigned BLOCK_SIZE   = 4;
  localparam int unsigned ADDR_W       = 11;
  localparam int unsigned DEC_ADDR_W   = 9;
  localparam int unsigned POS_W        = 8;
  localparam int unsigned STEP_W       = 24;
  // Option values
  localparam logic [7:0] OPT_INDEPENDENT = 8'h00;
  localparam logic [7:0] OPT_PAUSABLE    = 8'h01;
  localparam logic [7:0] OPT_COUPLED     = 8'h02;
  localparam logic [7:0] OPT_BARRIER     = 8'h80;
  // Servo position after reset
  localparam logic [7:0] POS_RESET       = 8'h7F;
  // Barrier sequence states
  typedef enum logic [2:0] {
    DSAC_B_IDLE,
    DSAC_B_WARN,
    DSAC_B_MOVE1,
    DSAC_B_PAUSE,
    DSAC_B_MOVE2,
    DSAC_B_TAIL,
    DSAC_B_OPEN
  } dsac_bstate_e;
endpackage

// >>> rtl/dsac_key.sv
// Classifies one local key press by its held time
module dsac_key #(
  parameter int unsigned DEBOUNCE_CYC = dsac_pkg::DEBOUNCE_CYC,
  parameter int unsigned LONG_CYC     = dsac_pkg::LONG_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_srst,
  input  wire logic i_key,        // Key level, high while pressed
  input  wire logic i_enable,     // Low while the pin is an output
  output logic      o_short,      // One-cycle pulse on a short release
  output logic      o_long        // One-cycle pulse on a long release
);
  logic [31:0] held_r;            // Cycles the key has been down

  // Count held time, saturating past the long threshold
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_enable || !i_key) begin
      held_r <= 32'h0000_0000;
    end else if (held_r <= LONG_CYC) begin
      held_r <= held_r + 32'h0000_0001;
    end
  end

  // Judge the press when the key is released
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_short <= 1'b0;
      o_long  <= 1'b0;
    end else begin
      o_short <= i_enable && !i_key && held_r >= DEBOUNCE_CYC
                 && held_r <= LONG_CYC;
      o_long  <= i_enable && !i_key && held_r > LONG_CYC;
    end
  end
endmodule // dsac_key

// >>> rtl/dsac_mover.sv
// Steps one servo position toward its target end stop
module dsac_mover #(
  parameter int unsigned POS_W  = dsac_pkg::POS_W,
  parameter int unsigned STEP_W = dsac_pkg::STEP_W
) (
  input  wire logic              i_clock,
  input  wire logic              i_srst,
  input  wire logic [POS_W-1:0]  i_left,       // Left end stop
  input  wire logic [POS_W-1:0]  i_right,      // Right end stop
  input  wire logic [STEP_W-1:0] i_step_cyc,   // Step period in cycles, less one
  input  wire logic              i_go,         // Start a movement
  input  wire logic              i_go_right,   // Target is the right stop
  input  wire logic              i_pause_tgl,  // Stop or continue
  output logic [POS_W-1:0]       o_position,   // Current position
  output logic                   o_moving,     // Movement not finished
  output logic                   o_mid         // Pulse at the midpoint
);
  logic [POS_W-1:0]  target_r;     // Destination stop
  logic              paused_r;     // Movement held
  logic [STEP_W-1:0] tick_r;       // Step timer
  logic [POS_W:0]    sum;          // Stop sum for the midpoint
  logic [POS_W-1:0]  mid;          // Midpoint between stops
  logic              step;         // Step now

  assign sum  = {1'b0, i_left} + {1'b0, i_right};
  assign mid  = sum[POS_W:1];
  assign step = o_moving && !paused_r && tick_r >= i_step_cyc;

  // Load a new target; a pause toggle applies only while moving
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      target_r <= dsac_pkg::POS_RESET;
      paused_r <= 1'b0;
    end else if (i_go) begin
      target_r <= i_go_right ? i_right : i_left;
      paused_r <= 1'b0;
    end else if (i_pause_tgl && o_moving) begin
      paused_r <= !paused_r;
    end
  end

  // Step timer and position
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tick_r     <= '0;
      o_position <= dsac_pkg::POS_RESET;
      o_mid      <= 1'b0;
    end else begin
      tick_r <= step ? '0 : (paused_r ? tick_r : tick_r + 1'b1);
      o_mid  <= step && ((o_position < target_r) ?
                (o_position + 1'b1 == mid) : (o_position - 1'b1 == mid));
      if (step) begin
        o_position <= (o_position < target_r) ? o_position + 1'b1
                                              : o_position - 1'b1;
      end
    end
  end

  assign o_moving = (o_position != target_r);
endmodule // dsac_mover

// >>> rtl/dsac_top.sv
// Behaviour
// - Servos use block addresses one and two
// - Turnout command moves servo between stops
// - Loco mode: F1/F2 changes move servos
// - Digital commands never pause a movement
// - Key one drives servo one, key two two
// - Short press goes left, long goes right
// - Option 1: press pauses or continues movement
// - Option 2: outputs follow their servos
// - Coupled output switches at stop midpoint
// - Option 0: outputs follow own commands
// - Outputs use block addresses three and four
// - Loco mode: F3/F4 drive the outputs
// - Barrier mode: servos close in turn, open together
// - One trigger runs whole barrier sequence
// - Barrier trigger: key two, address one, F1
// - Block ends at decoder address times four
// - Shared option 128 on, 0 off barrier
// - Barrier mode turns key one into output
module dsac_top #(
  parameter int unsigned DEBOUNCE_CYC = dsac_pkg::DEBOUNCE_CYC,
  parameter int unsigned LONG_CYC     = dsac_pkg::LONG_CYC,
  parameter int unsigned WARN_CYC     = dsac_pkg::WARN_CYC,
  parameter int unsigned PAUSE_CYC    = dsac_pkg::PAUSE_CYC,
  parameter int unsigned TAIL_CYC     = dsac_pkg::TAIL_CYC
) (
  input  wire logic                           i_clock,
  input  wire logic                           i_srst,
  // Decoded turnout command
  input  wire logic                           i_cmd_valid,
  input  wire logic [dsac_pkg::ADDR_W-1:0]    i_cmd_address,
  input  wire logic                           i_cmd_diverging,
  // Decoded function states F1..F4 of the loco address
  input  wire logic                           i_func_valid,
  input  wire logic [3:0]                     i_func_state,
  // Configuration
  input  wire logic                           i_loco_control,
  input  wire logic [dsac_pkg::DEC_ADDR_W-1:0] i_decoder_address,
  input  wire logic [7:0]                     i_shared_option_variable,
  input  wire logic [7:0]                     i_servo_option_setting_2,
  input  wire logic [15:0]                    i_left_stops,
  input  wire logic [15:0]                    i_right_stops,
  input  wire logic [47:0]                    i_step_cycles,
  // Local keys
  input  wire logic                           i_first_local_key,
  input  wire logic                           i_second_local_key,
  // Servo positions and switching outputs
  output logic [7:0]                          o_servo1_position,
  output logic [7:0]                          o_servo2_position,
  output logic                                o_first_switch_output,
  output logic                                o_second_switch_output,
  output logic                                o_third_switch_output,
  output logic                                o_third_switch_oe,
  output logic                                o_barrier_active
);
  localparam int unsigned AW = dsac_pkg::ADDR_W;

  logic [AW-1:0] block_high;      // Highest address of the block
  logic [AW-1:0] block_base;      // First address of the block
  logic          barrier;         // Barrier mode selected
  logic [3:0]    func_prev_r;     // Last seen function states
  logic [3:0]    func_chg;        // Function change pulses
  logic [3:0]    addr_hit;        // Command hits block address
  logic [1:0]    key_short;       // Short release per key
  logic [1:0]    key_long;        // Long release per key
  logic [1:0]    go;              // Start per servo
  logic [1:0]    go_right;        // Direction per servo
  logic [1:0]    pause_tgl;       // Pause toggle per servo
  logic [1:0]    moving;          // Servo moving
  logic [1:0]    mid;             // Midpoint pulse per servo
  logic [1:0]    dir_r;           // Latest start direction per servo
  logic [7:0]    pos [2];         // Positions
  logic [7:0]    opt [2];         // Option value per servo
  logic [1:0]    bar_go;          // Barrier starts per servo
  logic          bar_right;       // Barrier direction, right is closed
  logic          bar_trig;        // Barrier trigger

  dsac_pkg::dsac_bstate_e bstate_r; // Barrier sequence state
  logic [31:0]            btimer_r; // Barrier phase timer
  logic                   closed_r; // Barriers closed or closing
  logic                   lamp_r;   // Warning light
  logic                   sound_r;  // Acoustic signal

  // Block address from the decoder address
  assign block_high = AW'(i_decoder_address) * AW'(dsac_pkg::BLOCK_SIZE);
  assign block_base = block_high - AW'(dsac_pkg::BLOCK_SIZE - 1);

  // Barrier selection on the shared option value
  assign barrier = (i_shared_option_variable == dsac_pkg::OPT_BARRIER);

  // Option per servo; the shared variable doubles as servo one's setting
  assign opt[0] = i_shared_option_variable;
  assign opt[1] = i_servo_option_setting_2;

  // Remember function states to catch on and off switching
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      func_prev_r <= 4'h0;
    end else if (i_func_valid && i_loco_control) begin
      func_prev_r <= i_func_state;
    end
  end

  assign func_chg = (i_func_valid && i_loco_control) ?
                    (i_func_state ^ func_prev_r) : 4'h0;

  // Per-address command hits and per-servo control
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_addr
      // Turnout commands only count outside loco-command control
      assign addr_hit[g] = i_cmd_valid && !i_loco_control &&
                           (i_cmd_address == block_base + AW'(g));
    end
    for (g = 0; g < 2; g++) begin : g_servo
      logic dig_go;   // Digital request for this servo
      logic dig_dir;  // Digital direction
      logic key_any;  // Any judged press of the tied key

      // Turnout or function command for this servo
      assign dig_go  = addr_hit[g] || func_chg[g];
      assign dig_dir = addr_hit[g] ? i_cmd_diverging
                                   : i_func_state[g];
      assign key_any = key_short[g] || key_long[g];

      // Key presses pause when the option allows and a move runs
      assign pause_tgl[g] = !barrier && key_any && moving[g] &&
                            opt[g] == dsac_pkg::OPT_PAUSABLE;

      // Start requests; digital ones never toggle a pause
      always_comb begin
        if (barrier) begin
          go[g]       = bar_go[g];
          go_right[g] = bar_right;
        end else if (key_any && !pause_tgl[g]) begin
          go[g]       = 1'b1;
          go_right[g] = key_long[g];
        end else begin
          go[g]       = dig_go;
          go_right[g] = dig_dir;
        end
      end

      // Latest start direction, followed by the coupled output
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          dir_r[g] <= 1'b0;
        end else if (go[g]) begin
          dir_r[g] <= go_right[g];
        end
      end

      dsac_mover u_mover (
        .i_clock     (i_clock),
        .i_srst      (i_srst),
        .i_left      (i_left_stops[8*g +: 8]),
        .i_right     (i_right_stops[8*g +: 8]),
        .i_step_cyc  (i_step_cycles[24*g +: 24]),
        .i_go        (go[g]),
        .i_go_right  (go_right[g]),
        .i_pause_tgl (pause_tgl[g]),
        .o_position  (pos[g]),
        .o_moving    (moving[g]),
        .o_mid       (mid[g])
      );
    end
  endgenerate

  // First key is unusable while its pin serves as an output
  dsac_key #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC),
    .LONG_CYC     (LONG_CYC)
  ) u_key1 (
    .i_clock  (i_clock),
    .i_srst   (i_srst),
    .i_key    (i_first_local_key),
    .i_enable (!barrier),
    .o_short  (key_short[0]),
    .o_long   (key_long[0])
  );

  // Second key
  dsac_key #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC),
    .LONG_CYC     (LONG_CYC)
  ) u_key2 (
    .i_clock  (i_clock),
    .i_srst   (i_srst),
    .i_key    (i_second_local_key),
    .i_enable (1'b1),
    .o_short  (key_short[1]),
    .o_long   (key_long[1])
  );

  // Barrier trigger from key two, block address one or F1
  assign bar_trig = barrier && bstate_r == dsac_pkg::DSAC_B_IDLE &&
                    (key_short[1] || key_long[1] || addr_hit[0] ||
                     func_chg[0]);

  // Barrier servo starts and direction
  assign bar_right = closed_r;
  assign bar_go[0] = barrier &&
                     ((bstate_r == dsac_pkg::DSAC_B_WARN && btimer_r >= WARN_CYC) ||
                      (bstate_r == dsac_pkg::DSAC_B_OPEN && btimer_r == 32'h0));
  assign bar_go[1] = barrier &&
                     ((bstate_r == dsac_pkg::DSAC_B_PAUSE && btimer_r >= PAUSE_CYC) ||
                      (bstate_r == dsac_pkg::DSAC_B_OPEN && btimer_r == 32'h0));

  // Barrier sequence: close runs light, sound, servo, pause, servo
  always_ff @(posedge i_clock) begin
    if (i_srst || !barrier) begin
      bstate_r <= dsac_pkg::DSAC_B_IDLE;
      btimer_r <= 32'h0;
      closed_r <= 1'b0;
      lamp_r   <= 1'b0;
      sound_r  <= 1'b0;
    end else begin
      btimer_r <= btimer_r + 32'h1;
      case (bstate_r)
        dsac_pkg::DSAC_B_IDLE: begin
          btimer_r <= 32'h0;
          if (bar_trig && !closed_r) begin
            // Closing: warn first
            closed_r <= 1'b1;
            lamp_r   <= 1'b1;
            sound_r  <= 1'b1;
            bstate_r <= dsac_pkg::DSAC_B_WARN;
          end else if (bar_trig) begin
            // Opening: raise both barriers
            closed_r <= 1'b0;
            bstate_r <= dsac_pkg::DSAC_B_OPEN;
          end
        end
        dsac_pkg::DSAC_B_WARN: begin
          if (btimer_r >= WARN_CYC) begin
            btimer_r <= 32'h0;
            bstate_r <= dsac_pkg::DSAC_B_MOVE1;
          end
        end
        dsac_pkg::DSAC_B_MOVE1: begin
          btimer_r <= 32'h0;
          if (!moving[0]) begin
            bstate_r <= dsac_pkg::DSAC_B_PAUSE;
          end
        end
        dsac_pkg::DSAC_B_PAUSE: begin
          if (btimer_r >= PAUSE_CYC) begin
            btimer_r <= 32'h0;
            bstate_r <= dsac_pkg::DSAC_B_MOVE2;
          end
        end
        dsac_pkg::DSAC_B_MOVE2: begin
          btimer_r <= 32'h0;
          if (!moving[1]) begin
            bstate_r <= dsac_pkg::DSAC_B_TAIL;
          end
        end
        dsac_pkg::DSAC_B_TAIL: begin
          // Sound stops after a short tail; light stays while closed
          if (btimer_r >= TAIL_CYC) begin
            sound_r  <= 1'b0;
            bstate_r <= dsac_pkg::DSAC_B_IDLE;
          end
        end
        dsac_pkg::DSAC_B_OPEN: begin
          // Light goes out once both barriers are up
          if (btimer_r != 32'h0 && !moving[0] && !moving[1]) begin
            lamp_r   <= 1'b0;
            bstate_r <= dsac_pkg::DSAC_B_IDLE;
          end
        end
        default: begin
          bstate_r <= dsac_pkg::DSAC_B_IDLE;
        end
      endcase
    end
  end

  // Switching outputs one and two
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_first_switch_output  <= 1'b0;
      o_second_switch_output <= 1'b0;
    end else if (barrier) begin
      // Both carry the warning light
      o_first_switch_output  <= lamp_r;
      o_second_switch_output <= lamp_r;
    end else begin
      if (opt[0] == dsac_pkg::OPT_COUPLED && mid[0]) begin
        o_first_switch_output <= dir_r[0];
      end else if (opt[0] == dsac_pkg::OPT_INDEPENDENT && addr_hit[2]) begin
        o_first_switch_output <= i_cmd_diverging;
      end else if (opt[0] == dsac_pkg::OPT_INDEPENDENT && func_chg[2]) begin
        o_first_switch_output <= i_func_state[2];
      end
      if (opt[1] == dsac_pkg::OPT_COUPLED && mid[1]) begin
        o_second_switch_output <= dir_r[1];
      end else if (opt[1] == dsac_pkg::OPT_INDEPENDENT && addr_hit[3]) begin
        o_second_switch_output <= i_cmd_diverging;
      end else if (opt[1] == dsac_pkg::OPT_INDEPENDENT && func_chg[3]) begin
        o_second_switch_output <= i_func_state[3];
      end
    end
  end

  // Third output on the first key pin, acoustic signal
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_third_switch_output <= 1'b0;
      o_third_switch_oe     <= 1'b0;
      o_barrier_active      <= 1'b0;
    end else begin
      o_third_switch_output <= barrier && sound_r;
      o_third_switch_oe     <= barrier;
      o_barrier_active      <= barrier;
    end
  end

  // Servo positions, already registered in the movers
  assign o_servo1_position = pos[0];
  assign o_servo2_position = pos[1];
endmodule // dsac_top

// >>> verif/dsac_sva.sv
// Port-level checks on the servo control block
module dsac_sva (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_cmd_valid,
  input wire logic [10:0] i_cmd_address,
  input wire logic        i_cmd_diverging,
  input wire logic        i_func_valid,
  input wire logic        i_loco_control,
  input wire logic [8:0]  i_decoder_address,
  input wire logic [7:0]  i_shared_option_variable,
  input wire logic [7:0]  i_servo_option_setting_2,
  input wire logic [47:0] i_step_cycles,
  input wire logic [7:0]  o_servo1_position,
  input wire logic        o_first_switch_output,
  input wire logic        o_second_switch_output,
  input wire logic        o_third_switch_output,
  input wire logic        o_third_switch_oe,
  input wire logic        o_barrier_active
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  logic [10:0] blk_top;  // Highest address of the block
  logic        in_blk;   // Command aimed inside the block
  logic        indep;    // Both options independent
  assign blk_top = {i_decoder_address, 2'b00};
  assign in_blk  = (i_cmd_address <= blk_top) && (i_cmd_address >= blk_top - 11'h003);
  assign indep   = (i_shared_option_variable == 8'h00) && (i_servo_option_setting_2 == 8'h00);
  property p_bar_on;
    (i_shared_option_variable == 8'h80) |=> o_barrier_active && o_third_switch_oe;
  endproperty
  a_bar_on: assert property (p_bar_on) else $error("barrier mode not entered");
  property p_bar_off;
    (i_shared_option_variable == 8'h00) |=> !o_barrier_active && !o_third_switch_oe;
  endproperty
  a_bar_off: assert property (p_bar_off) else $error("barrier mode not left");
  // Servo moves one count per step
  property p_step;
    $changed(o_servo1_position) |-> (o_servo1_position == $past(o_servo1_position) + 8'h01)
      || (o_servo1_position == $past(o_servo1_position) - 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("servo jumped");
  property p_space;
    (i_step_cycles[23:0] != 24'h000000) && $changed(o_servo1_position)
      |=> $stable(o_servo1_position);
  endproperty
  a_space: assert property (p_space) else $error("servo stepped too fast");
  property p_out_cmd;
    i_cmd_valid && !i_loco_control && indep && i_cmd_diverging
      && (i_cmd_address == blk_top - 11'h001) |-> ##[1:2] o_first_switch_output;
  endproperty
  a_out_cmd: assert property (p_out_cmd) else $error("output ignored its command");
  // Refused commands leave the outputs alone
  property p_refuse;
    i_cmd_valid && !i_func_valid && indep && (i_loco_control || !in_blk)
      |=> ($stable(o_first_switch_output) && $stable(o_second_switch_output)) [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused command acted");
  property p_lamp;
    o_barrier_active && $rose(o_third_switch_output)
      |-> o_first_switch_output && o_second_switch_output;
  endproperty
  a_lamp: assert property (p_lamp) else $error("sound without lamps");
  // Warning lead keeps the barrier still for at least four cycles
  property p_warn;
    o_barrier_active && $rose(o_third_switch_output) |=> $stable(o_servo1_position) [*4];
  endproperty
  a_warn: assert property (p_warn) else $error("barrier moved during warning");
  c_close: cover property ($rose(o_third_switch_output));
  c_refuse: cover property (i_cmd_valid && indep && !in_blk);
  c_out: cover property (i_cmd_valid && indep && (i_cmd_address == blk_top - 11'h001));
endmodule // dsac_sva

bind dsac_top dsac_sva i_sva (.*);

// >>> verif/dsac_station.sv
// Stands in for the command station and the two local keys
module dsac_station (
  input  wire logic   i_clock,
  output logic        o_cmd_valid,
  output logic [10:0] o_cmd_address,
  output logic        o_cmd_diverging,
  output logic        o_func_valid,
  output logic [3:0]  o_func_state,
  output logic [1:0]  o_keys         // Key levels, bit 1 is the second key
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels from time zero
  initial begin
    o_cmd_valid     = 1'b0;
    o_cmd_address   = 11'h000;
    o_cmd_diverging = 1'b0;
    o_func_valid    = 1'b0;
    o_func_state    = 4'h0;
    o_keys          = 2'b00;
  end
  // One-cycle command; lines flip once the pulse is over
  task automatic send_cmd(input logic [10:0] addr, input logic div);
    @(negedge i_clock);
    o_cmd_valid     = 1'b1;
    o_cmd_address   = addr;
    o_cmd_diverging = div;
    @(negedge i_clock);
    o_cmd_valid     = 1'b0;
    o_cmd_address   = ~addr;
    o_cmd_diverging = ~div;
  endtask
  // One-cycle function update
  task automatic send_func(input logic [3:0] f);
    @(negedge i_clock);
    o_func_valid = 1'b1;
    o_func_state = f;
    @(negedge i_clock);
    o_func_valid = 1'b0;
    o_func_state = ~f;
  endtask
  // Holds a key for the given cycles, then lets it go
  task automatic press(input int key, input int held);
    @(negedge i_clock);
    o_keys[key] = 1'b1;
    repeat (held) @(negedge i_clock);
    o_keys[key] = 1'b0;
    repeat (4) @(negedge i_clock);
  endtask
endmodule // dsac_station

// >>> verif/dsac_top_test.sv
// Sequenced tests of the two-servo control block
module dsac_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [10:0] BASE = 11'h025;  // First block address of decoder 10
  localparam logic [7:0]  L1 = 8'h10;
  localparam logic [7:0]  R1 = 8'h20;
  localparam logic [7:0]  L2 = 8'h30;
  localparam logic [7:0]  R2 = 8'h40;
  logic        i_clock, i_srst, loco, cmd_v, cmd_d, func_v;
  logic        out1, out2, out3, oe, bar;
  logic [7:0]  opt1, opt2, pos1, pos2, held;
  logic [10:0] cmd_a;
  logic [3:0]  func_s;
  logic [1:0]  keys;
  logic [8:0]  dec_a = 9'h00A;
  logic [15:0] lft = {L2, L1};
  logic [15:0] rgt = {R2, R1};
  logic [47:0] stp = 48'h000003000003;
  int          mismatches = 0;
  int          cmp_count = 0;
  dsac_station st (.i_clock(i_clock), .o_cmd_valid(cmd_v), .o_cmd_address(cmd_a),
    .o_cmd_diverging(cmd_d), .o_func_valid(func_v), .o_func_state(func_s), .o_keys(keys));
  dsac_top #(.DEBOUNCE_CYC(2), .LONG_CYC(20), .WARN_CYC(5), .PAUSE_CYC(5), .TAIL_CYC(5))
  i_dut (.i_clock(i_clock), .i_srst(i_srst), .i_cmd_valid(cmd_v), .i_cmd_address(cmd_a),
    .i_cmd_diverging(cmd_d), .i_func_valid(func_v), .i_func_state(func_s),
    .i_loco_control(loco), .i_decoder_address(dec_a), .i_shared_option_variable(opt1),
    .i_servo_option_setting_2(opt2), .i_left_stops(lft), .i_right_stops(rgt),
    .i_step_cycles(stp), .i_first_local_key(keys[0]),
    .i_second_local_key(keys[1]), .o_servo1_position(pos1), .o_servo2_position(pos2),
    .o_first_switch_output(out1), .o_second_switch_output(out2),
    .o_third_switch_output(out3), .o_third_switch_oe(oe), .o_barrier_active(bar));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [7:0] probe(input int sel);
    case (sel)
      0: return pos1;
      1: return pos2;
      default: return {7'h00, out3};
    endcase
  endfunction
  // Bounded wait for a position or the sound output
  task automatic wait_for(input int sel, input logic [7:0] exp, input string msg);
    int n;
    n = 0;
    while (probe(sel) !== exp && n < 1000) begin
      @(negedge i_clock);
      n++;
    end
    check(probe(sel), exp, msg);
  endtask
  // Watchdog well past the expected run
  initial begin
    #200000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    i_srst = 1'b1;
    loco   = 1'b0;
    opt1   = 8'h00;
    opt2   = 8'h00;
    repeat (2) @(negedge i_clock);
    i_srst = 1'b0;
    check(pos1, 8'h7F, "reset position");
    st.send_cmd(BASE, 1'b1);
    wait_for(0, R1, "servo1 cmd");
    st.send_cmd(BASE + 11'h001, 1'b0);
    wait_for(1, L2, "servo2 cmd");
    st.send_cmd(BASE + 11'h002, 1'b1);
    st.send_cmd(BASE + 11'h003, 1'b1);
    st.send_cmd(BASE - 11'h001, 1'b0);
    st.send_cmd(BASE + 11'h004, 1'b0);
    repeat (12) @(negedge i_clock);
    check({6'h00, out1, out2}, 8'h03, "independent outputs");
    check(pos1, R1, "outside block");
    $display("independent test done");
    opt1 = 8'h02;
    opt2 = 8'h02;
    st.send_cmd(BASE, 1'b0);
    wait_for(0, 8'h19, "before midpoint");
    check({7'h00, out1}, 8'h01, "output before midpoint");
    wait_for(0, 8'h18, "midpoint");
    repeat (2) @(negedge i_clock);
    check({7'h00, out1}, 8'h00, "output at midpoint");
    wait_for(0, L1, "servo1 left");
    st.press(0, 30);
    wait_for(0, R1, "key1 long");
    check({7'h00, out1}, 8'h01, "coupled by key");
    st.press(1, 30);
    wait_for(1, R2, "key2 long");
    check({7'h00, out2}, 8'h01, "coupled output2");
    st.press(1, 5);
    wait_for(1, L2, "key2 short");
    check({7'h00, out2}, 8'h00, "coupled output2 off");
    $display("coupled test done");
    opt2 = 8'h01;
    st.press(1, 30);
    wait_for(1, 8'h35, "moving");
    st.press(1, 5);
    held = pos2;
    repeat (40) @(negedge i_clock);
    check(pos2, held, "paused");
    st.press(1, 5);
    wait_for(1, R2, "resumed");
    $display("pause test done");
    opt1 = 8'h00;
    opt2 = 8'h00;
    loco = 1'b1;
    st.send_func(4'h3);
    st.send_func(4'h0);
    wait_for(0, L1, "F1 off");
    wait_for(1, L2, "F2 off");
    st.send_cmd(BASE, 1'b1);
    repeat (12) @(negedge i_clock);
    check(pos1, L1, "turnout under loco");
    st.send_func(4'hC);
    repeat (3) @(negedge i_clock);
    check({6'h00, out1, out2}, 8'h03, "F3 F4 on");
    st.send_func(4'h0);
    repeat (3) @(negedge i_clock);
    check({6'h00, out1, out2}, 8'h00, "F3 F4 off");
    $display("loco test done");
    loco = 1'b0;
    opt1 = 8'h80;
    repeat (2) @(negedge i_clock);
    check({6'h00, bar, oe}, 8'h03, "barrier on");
    st.press(1, 5);
    check({5'h00, out1, out2, out3}, 8'h07, "closing");
    wait_for(0, R1, "barrier1 closed");
    wait_for(1, R2, "barrier2 closed");
    wait_for(2, 8'h00, "sound off");
    check({6'h00, out1, out2}, 8'h03, "lamps on");
    st.send_cmd(BASE, 1'b0);
    wait_for(0, L1, "barrier1 open");
    wait_for(1, L2, "barrier2 open");
    repeat (3) @(negedge i_clock);
    check({5'h00, out1, out2, out3}, 8'h00, "opened");
    loco = 1'b1;
    st.send_func(4'h1);
    repeat (3) @(negedge i_clock);
    check({7'h00, out3}, 8'h01, "F1 trigger");
    wait_for(2, 8'h00, "sound off again");
    opt1 = 8'h00;
    loco = 1'b0;
    repeat (2) @(negedge i_clock);
    check({6'h00, bar, oe}, 8'h00, "barrier off");
    $display("barrier test done");
    stop_test();
  end
endmodule // dsac_top_test
